// file: deser_cfg_defines.vh
// Register offsets, field positions, reset values and strap encodings for
// the deserializer general configuration register bank.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef DESER_CFG_DEFINES_VH
`define DESER_CFG_DEFINES_VH

// ==========================================================================
// Register offsets
`define ADDR_BUS_ADDRESS 8'h00
`define ADDR_SOFT_RESET 8'h01
`define ADDR_OUTPUT_MODE 8'h02
`define ADDR_LINK_CONTROL 8'h03

// ==========================================================================
// Reset values
`define RST_SOFT_RESET 8'h04
`define RST_OUTPUT_MODE 8'h00
`define RST_LINK_CONTROL 8'hF0
`define STRAP_DEFAULT_ADDR 7'h2C

// ==========================================================================
// Field positions
`define BIT_ADDR_SRC 0
`define BIT_FULL_RST 1
`define BIT_LOGIC_RST 0
`define BIT_RET_EN 2
`define BIT_OUT_EN 7
`define BIT_OVR_OUT 6
`define BIT_OSC_OUT 5
`define BIT_SLEEP_SEL 4
`define BIT_LEGACY_OVR 3
`define BIT_LEGACY 2
`define BIT_LOWRATE_OVR 1
`define BIT_LOWRATE 0
`define BIT_CRC_EN 6
`define BIT_PULL_DN 5
`define BIT_FILT_EN 4
`define BIT_PASS_EN 3
`define BIT_AUTO_ACK 2

// ==========================================================================
// Reserved bit masks and address strap encoding
`define MASK_SOFT_RESET 8'h07
`define MASK_LINK_CONTROL 8'h7C
`define RSV_LINK_CONTROL 8'h80
`define STRAP_W 4
`define STRAP_CODES 4'h9
// Clocks after reset release before the strap chain holds real pin samples.
`define STRAP_SETTLE 2'h3

// Glitch filter length in clocks: pulses shorter than this are rejected.
`define FILT_LEN 2'h2

`endif

// file: sync_glitch_filter.v
// Three-stage synchroniser followed by an optional two-clock pulse filter.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/1ps

module sync_glitch_filter (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Control
    input wire filt_en,
    // Data
    input wire din,
    output reg dout
);

`include "deser_cfg_defines.vh"

reg s1;
reg s2;
reg s3;
reg [1:0] run;

// ==========================================================================
// Synchroniser and filter
// With the filter off, the second and third stages must agree before a change counts; with the
// filter on, the third stage must hold the new level for two full clocks,
// so a pulse of exactly two clocks passes and a shorter one is dropped.
always @(posedge clk_sys) begin
    if (!nrst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        run <= 2'h0;
        dout <= 1'b0;
    end else begin
        s1 <= din;
        s2 <= s1;
        s3 <= s2;
        if (s3 == dout) begin
            run <= 2'h0;
        end else if (filt_en ? (run + 2'h1 >= `FILT_LEN) : (s2 == s3)) begin
            dout <= s3;
            run <= 2'h0;
        end else begin
            run <= run + 2'h1;
        end
    end
end

endmodule

// file: deser_general_config_regs.v
// General configuration register bank of a video deserializer: bus address,
// soft resets, output-mode and link-control registers.
// Assumes a serial control bus slave on clk_sys delivers byte reads and
// writes through the reg_* port, and a link receiver supplies lock.
//
// Summary of operation
// - Address field writable only with override set
// - Address from strap, or register when override
// - Full soft reset clears registers, self-clears
// - Logic soft reset keeps registers, self-clears
// - Output enable bit cleared on lock loss
// - Override lets register drive enable and sleep
// - Oscillator clock on clock pair after lock loss
// - Sleep select: tristate or sleep while unlocked
// - Legacy mode from pin unless override bit
// - Low-rate mode from pin unless override bit
// - Return channel CRC enable, default on
// - Failsafe pull direction, default pull-down
// - Reject sync pulses under two clocks
// - Pass-through of aliased transactions when enabled
// - Acknowledge regardless of lock when enabled
// - Ten bus addresses decoded from strap
// - Registers reached over shared serial control bus
`timescale 1ns/1ps

module deser_general_config_regs (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Register access from the serial control bus slave
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // Device pins and link status
    input wire [3:0] address_strap_pin,
    input wire legacy_mode_pin,
    input wire low_rate_pin,
    input wire lock,
    input wire de_in,
    input wire hsync_in,
    input wire vsync_in,
    // Control outputs
    output reg [6:0] bus_addr,
    output reg output_drive_enable,
    output reg output_sleep_state_select,
    output reg osc_to_output_clock_pair,
    output reg legacy_compat_mode,
    output reg low_rate_mode,
    output reg return_channel_enable,
    output reg crc_enable,
    output reg pull_down_select,
    output reg passthrough_enable,
    output reg auto_ack_enable,
    output reg logic_reset,
    output reg de_out,
    output reg hsync_out,
    output reg vsync_out
);

`include "deser_cfg_defines.vh"

// Registers.
reg [6:0] addr_field;
reg addr_src;
reg [7:0] soft_reset_control;
reg [7:0] output_mode_config;
reg [7:0] link_control_config;
// Synchronisers for pins.
reg [3:0] strap_s1;
reg [3:0] strap_s2;
reg [3:0] strap_s3;
reg [3:0] strap_q;
reg [2:0] leg_sync;
reg leg_q;
reg [2:0] lr_sync;
reg lr_q;
reg [2:0] lock_sync;
reg lock_q;
reg lock_prev;
reg strap_caught;
reg [1:0] strap_fill;
reg full_reset_pend;
reg [6:0] strap_addr;
wire regs_rst;
wire lock_fall;
wire de_f;
wire hs_f;
wire vs_f;
wire out_en_eff;
wire sleep_eff;

// ==========================================================================
// Helper functions

// Maps a strap level code to one of ten bus addresses; out-of-range codes
// fall back to the first address.
function [6:0] strap_decode;
    input [3:0] code;
    begin
        if (code > `STRAP_CODES) begin
            strap_decode = `STRAP_DEFAULT_ADDR;
        end else begin
            strap_decode = `STRAP_DEFAULT_ADDR + {3'h0, code}
                + ((code != 4'h0) ? 7'h06 : 7'h00);
        end
    end
endfunction

// Tests whether a write lands on the given offset.
function wr_hit;
    input we;
    input [7:0] a;
    input [7:0] target;
    begin
        wr_hit = we && (a == target);
    end
endfunction

// ==========================================================================
// Pin synchronisers: three stages, a change counts once stages 2 and 3 agree.
always @(posedge clk_sys) begin
    if (!nrst) begin
        strap_s1 <= 4'h0;
        strap_s2 <= 4'h0;
        strap_s3 <= 4'h0;
        strap_q <= 4'h0;
        leg_sync <= 3'h0;
        leg_q <= 1'b0;
        lr_sync <= 3'h0;
        lr_q <= 1'b0;
        lock_sync <= 3'h0;
        lock_q <= 1'b0;
    end else begin
        strap_s1 <= address_strap_pin;
        strap_s2 <= strap_s1;
        strap_s3 <= strap_s2;
        if (strap_s2 == strap_s3) begin
            strap_q <= strap_s3;
        end
        leg_sync <= {leg_sync[1:0], legacy_mode_pin};
        if (leg_sync[1] == leg_sync[2]) begin
            leg_q <= leg_sync[2];
        end
        lr_sync <= {lr_sync[1:0], low_rate_pin};
        if (lr_sync[1] == lr_sync[2]) begin
            lr_q <= lr_sync[2];
        end
        lock_sync <= {lock_sync[1:0], lock};
        if (lock_sync[1] == lock_sync[2]) begin
            lock_q <= lock_sync[2];
        end
    end
end

// ==========================================================================
// Strap capture: the strapped address is latched once after reset release,
// when the synchroniser has settled. The fill count keeps the reset zeros
// of the chain from being mistaken for a strap code.
always @(posedge clk_sys) begin
    if (!nrst) begin
        strap_caught <= 1'b0;
        strap_fill <= 2'h0;
        strap_addr <= `STRAP_DEFAULT_ADDR;
    end else begin
        if (strap_fill != `STRAP_SETTLE) begin
            strap_fill <= strap_fill + 2'h1;
        end
        if (!strap_caught && strap_fill == `STRAP_SETTLE && strap_s2 == strap_s3
                && strap_q == strap_s3) begin
            strap_caught <= 1'b1;
            strap_addr <= strap_decode(strap_q);
        end
    end
end

// Lock edge detect on the filtered lock level.
always @(posedge clk_sys) begin
    if (!nrst) begin
        lock_prev <= 1'b0;
    end else begin
        lock_prev <= lock_q;
    end
end

assign lock_fall = lock_prev && !lock_q;

// Register reset: device reset or the one-cycle full soft reset.
assign regs_rst = !nrst || full_reset_pend;

// ==========================================================================
// Register writes over the serial control bus.
always @(posedge clk_sys) begin
    if (regs_rst) begin
        addr_field <= `STRAP_DEFAULT_ADDR;
        addr_src <= 1'b0;
        soft_reset_control <= `RST_SOFT_RESET;
        output_mode_config <= `RST_OUTPUT_MODE;
        link_control_config <= `RST_LINK_CONTROL;
    end else begin
        // Address field follows the strap until override is enabled.
        if (wr_hit(reg_wr, reg_addr, `ADDR_BUS_ADDRESS)) begin
            addr_src <= reg_wdata[`BIT_ADDR_SRC];
            if (reg_wdata[`BIT_ADDR_SRC] || addr_src) begin
                addr_field <= reg_wdata[7:1];
            end
        end else if (!addr_src) begin
            addr_field <= strap_addr;
        end
        // Reset bits pulse for one cycle; the enable bit stores.
        if (wr_hit(reg_wr, reg_addr, `ADDR_SOFT_RESET)) begin
            soft_reset_control <= (reg_wdata & `MASK_SOFT_RESET)
                | (soft_reset_control & ~`MASK_SOFT_RESET);
        end else begin
            soft_reset_control[`BIT_FULL_RST] <= 1'b0;
            soft_reset_control[`BIT_LOGIC_RST] <= 1'b0;
        end
        // Lock loss clears output enable; a write in the same cycle lands in bits 6:0 only.
        if (lock_fall) begin
            output_mode_config[`BIT_OUT_EN] <= 1'b0;
            if (wr_hit(reg_wr, reg_addr, `ADDR_OUTPUT_MODE)) begin
                output_mode_config[6:0] <= reg_wdata[6:0];
            end
        end else if (wr_hit(reg_wr, reg_addr, `ADDR_OUTPUT_MODE)) begin
            output_mode_config <= reg_wdata;
        end
        // Reserved bit 7 and the low bits keep their defaults.
        if (wr_hit(reg_wr, reg_addr, `ADDR_LINK_CONTROL)) begin
            link_control_config <= (reg_wdata & `MASK_LINK_CONTROL)
                | (`RST_LINK_CONTROL & ~`MASK_LINK_CONTROL);
        end
    end
end

// Full soft reset request delayed one cycle so the write completes first.
always @(posedge clk_sys) begin
    if (!nrst) begin
        full_reset_pend <= 1'b0;
    end else begin
        full_reset_pend <= soft_reset_control[`BIT_FULL_RST];
    end
end

// ==========================================================================
// Register reads; unlisted offsets read as zero.
always @(posedge clk_sys) begin
    if (!nrst) begin
        reg_rdata <= 8'h00;
        reg_rvalid <= 1'b0;
    end else begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                `ADDR_BUS_ADDRESS: reg_rdata <= {bus_addr, addr_src};
                `ADDR_SOFT_RESET: reg_rdata <= soft_reset_control;
                `ADDR_OUTPUT_MODE: reg_rdata <= output_mode_config;
                `ADDR_LINK_CONTROL: reg_rdata <= link_control_config;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end
end

// ==========================================================================
// Effective output controls: with override the register decides, otherwise
// enable follows the lock state and sleep select stays 0.
assign out_en_eff = output_mode_config[`BIT_OVR_OUT] ?
    output_mode_config[`BIT_OUT_EN] : lock_q;
assign sleep_eff = output_mode_config[`BIT_OVR_OUT] ?
    output_mode_config[`BIT_SLEEP_SEL] : 1'b0;

// Registered control outputs.
always @(posedge clk_sys) begin
    if (!nrst) begin
        bus_addr <= `STRAP_DEFAULT_ADDR;
        output_drive_enable <= 1'b0;
        output_sleep_state_select <= 1'b0;
        osc_to_output_clock_pair <= 1'b0;
        legacy_compat_mode <= 1'b0;
        low_rate_mode <= 1'b0;
        return_channel_enable <= 1'b0;
        crc_enable <= 1'b0;
        pull_down_select <= 1'b0;
        passthrough_enable <= 1'b0;
        auto_ack_enable <= 1'b0;
        logic_reset <= 1'b0;
    end else begin
        bus_addr <= addr_src ? addr_field : strap_addr;
        // Outputs drive only while locked, or as the override dictates.
        output_drive_enable <= out_en_eff && (lock_q || !sleep_eff);
        // While unlocked, sleep state or tristate per the select bit.
        output_sleep_state_select <= !lock_q && sleep_eff;
        osc_to_output_clock_pair <= !lock_q
            && output_mode_config[`BIT_OSC_OUT];
        legacy_compat_mode <= output_mode_config[`BIT_LEGACY_OVR] ?
            output_mode_config[`BIT_LEGACY] : leg_q;
        low_rate_mode <= output_mode_config[`BIT_LOWRATE_OVR] ?
            output_mode_config[`BIT_LOWRATE] : lr_q;
        return_channel_enable <= soft_reset_control[`BIT_RET_EN];
        crc_enable <= link_control_config[`BIT_CRC_EN];
        pull_down_select <= link_control_config[`BIT_PULL_DN];
        passthrough_enable <= link_control_config[`BIT_PASS_EN];
        auto_ack_enable <= link_control_config[`BIT_AUTO_ACK];
        logic_reset <= soft_reset_control[`BIT_LOGIC_RST]
            || soft_reset_control[`BIT_FULL_RST];
    end
end

// ==========================================================================
// Sync-signal filters on data enable, horizontal and vertical sync.
sync_glitch_filter u_filt_de (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .filt_en(link_control_config[`BIT_FILT_EN]),
    .din(de_in),
    .dout(de_f)
);

sync_glitch_filter u_filt_hs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .filt_en(link_control_config[`BIT_FILT_EN]),
    .din(hsync_in),
    .dout(hs_f)
);

sync_glitch_filter u_filt_vs (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .filt_en(link_control_config[`BIT_FILT_EN]),
    .din(vsync_in),
    .dout(vs_f)
);

// Filtered sync outputs, registered once more at the top.
always @(posedge clk_sys) begin
    if (!nrst) begin
        de_out <= 1'b0;
        hsync_out <= 1'b0;
        vsync_out <= 1'b0;
    end else begin
        de_out <= de_f;
        hsync_out <= hs_f;
        vsync_out <= vs_f;
    end
end

endmodule

// file: deser_cfg_host.sv
// Host model for the register port of the configuration bank.
// Assumes the bench calls wr and rd by hierarchy, one at a time.
`timescale 1ns/1ps
module deser_cfg_host (
    // Clock
    input wire clk_sys,
    // Register access
    output reg reg_wr,
    output reg reg_rd,
    output reg [7:0] reg_addr,
    output reg [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid
);
    // =====
    // Requests start at a falling edge and hold over one rising edge.
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Random idle gap so the bank sees prompt and slow hosts.
    task gap;
        begin
            repeat (1 + $urandom % 3) @(negedge clk_sys);
        end
    endtask
    // Reserved fields are always sent at their defaults.
    task wr(input [7:0] a, input [7:0] d);
        begin
            gap;
            reg_addr = a;
            reg_wdata = (a == 8'h01) ? (d & 8'h07) : (a == 8'h03) ? ((d & 8'h7C) | 8'h80) : d;
            reg_wr = 1'b1;
            @(negedge clk_sys);
            reg_wr = 1'b0;
            reg_addr = ~reg_addr;
            reg_wdata = ~reg_wdata;
        end
    endtask
    // Read data is taken in the cycle after the request.
    task rd(input [7:0] a, output [7:0] d, output v);
        begin
            gap;
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk_sys);
            d = reg_rdata;
            v = reg_rvalid;
            reg_rd = 1'b0;
            reg_addr = ~reg_addr;
        end
    endtask
endmodule

// file: deser_general_config_regs_props.sv
// Checker for the general configuration register bank.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
module deser_general_config_regs_props (
    // Clock and reset
    input wire clk_sys,
    input wire nrst,
    // Register access
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire reg_rvalid,
    // Status and controls
    input wire lock,
    input wire [6:0] bus_addr,
    input wire output_drive_enable,
    input wire legacy_compat_mode,
    input wire low_rate_mode,
    input wire crc_enable,
    input wire pull_down_select,
    input wire passthrough_enable,
    input wire auto_ack_enable,
    input wire logic_reset
);
    // =====
    // Assertions tie bus address, mode, link and logic reset outputs to their writes, and output enable to lock loss.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire wr0 = reg_wr && reg_addr == 8'h00;
    wire wr1 = reg_wr && reg_addr == 8'h01;
    wire wr2 = reg_wr && reg_addr == 8'h02;
    wire wr3 = reg_wr && reg_addr == 8'h03;
    property p_addr;
        wr0 && reg_wdata[0] |-> ##2 bus_addr == $past(reg_wdata[7:1], 2);
    endproperty
    property p_link;
        wr3 |-> ##2 {crc_enable, pull_down_select, passthrough_enable, auto_ack_enable}
            == {$past(reg_wdata[6:5], 2), $past(reg_wdata[3:2], 2)};
    endproperty
    property p_mode;
        wr2 && reg_wdata[3] && reg_wdata[1] |-> ##2 {legacy_compat_mode, low_rate_mode}
            == {$past(reg_wdata[2], 2), $past(reg_wdata[0], 2)};
    endproperty
    AST_ADDR_SRC: assert property (p_addr)
        else $error("bus address not taken from register");
    AST_LINK_BITS: assert property (p_link)
        else $error("link control outputs do not follow write");
    AST_MODE_OVR: assert property (p_mode)
        else $error("mode override not applied");
    AST_LOCK_FALL: assert property ($fell(lock) ##1 !lock [*7] |-> !output_drive_enable)
        else $error("outputs still enabled after lock loss");
    AST_FULL_RST: assert property (wr1 && reg_wdata[1] |-> ##[2:4] crc_enable &&
        pull_down_select && !passthrough_enable && !auto_ack_enable)
        else $error("full soft reset did not restore defaults");
    AST_LOGIC_RST: assert property (wr1 && (reg_wdata[0] || reg_wdata[1]) |-> ##[1:2] logic_reset)
        else $error("soft reset pulse missing");
    AST_RVALID: assert property (##1 reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after read");
    AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h03 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    cover property (wr1 && reg_wdata[1]);
    cover property ($fell(lock));
    cover property (reg_rd && reg_addr > 8'h03);
endmodule
bind deser_general_config_regs deser_general_config_regs_props i_props (.clk_sys(clk_sys),
    .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .lock(lock), .bus_addr(bus_addr),
    .output_drive_enable(output_drive_enable), .legacy_compat_mode(legacy_compat_mode),
    .low_rate_mode(low_rate_mode), .crc_enable(crc_enable), .pull_down_select(pull_down_select),
    .passthrough_enable(passthrough_enable), .auto_ack_enable(auto_ack_enable),
    .logic_reset(logic_reset));

// file: deser_general_config_regs_test.sv
// Self-checking bench for the general configuration register bank.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
module deser_general_config_regs_test;
    reg clk_sys, nrst, lock, leg_pin, low_pin, de_in, hsync_in, vsync_in, vld, traffic;
    reg [3:0] strap;
    reg [7:0] rv, d;
    reg [2:0] pulse, seen;
    wire reg_wr, reg_rd, reg_rvalid, ode, oss, osc, leg, low, ret, crc, pdn, pas, ack;
    wire lrst, de_o, hs_o, vs_o;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [6:0] bus_addr;
    integer miscompares, n_compared, i;
    integer cycles = 0;
    integer mdl [0:3];
    deser_cfg_host i_host (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    deser_general_config_regs i_dut (.clk_sys(clk_sys), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .address_strap_pin(strap), .legacy_mode_pin(leg_pin),
        .low_rate_pin(low_pin), .lock(lock), .de_in(de_in), .hsync_in(hsync_in),
        .vsync_in(vsync_in), .bus_addr(bus_addr), .output_drive_enable(ode),
        .output_sleep_state_select(oss), .osc_to_output_clock_pair(osc),
        .legacy_compat_mode(leg), .low_rate_mode(low), .return_channel_enable(ret),
        .crc_enable(crc), .pull_down_select(pdn), .passthrough_enable(pas),
        .auto_ack_enable(ack), .logic_reset(lrst), .de_out(de_o), .hsync_out(hs_o),
        .vsync_out(vs_o));
    // =====
    // Clock, timeout and random sync traffic.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    end
    always @(negedge clk_sys) {de_in, hsync_in, vsync_in} <= traffic ? 3'($urandom) : pulse;
    // Reference model helpers.
    function [6:0] eff;
        input integer r0;
        eff = r0[0] ? r0[7:1] : ((strap == 0 || strap > 9) ? 7'h2C : 7'h32 + strap);
    endfunction
    task check(input [7:0] seen, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task reset_mdl;
        begin
            mdl[0] = {eff(0), 1'b0};
            mdl[1] = 8'h04;
            mdl[2] = 8'h00;
            mdl[3] = 8'hF0;
        end
    endtask
    task wreg(input [7:0] a, input [7:0] dd);
        begin
            i_host.wr(a, dd);
            if (a == 8'h00) mdl[0] = (dd[0] || mdl[0][0]) ? dd : (mdl[0] & 8'hFE);
            if (a == 8'h01) mdl[1] = dd & 8'h04;
            if (a == 8'h01 && dd[1]) reset_mdl;
            if (a == 8'h02) mdl[2] = dd;
            if (a == 8'h03) mdl[3] = (dd & 8'h7C) | 8'h80;
        end
    endtask
    task rcheck(input [7:0] a);
        begin
            i_host.rd(a, rv, vld);
            check(vld, 1);
            check(rv, (a == 0) ? {eff(mdl[0]), mdl[0][0]} : (a < 4) ? mdl[a] : 0);
        end
    endtask
    task wrap_up;
        begin
            $display("compared %0d, mismatched %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    // Main sequence of tests.
    initial begin
        miscompares = 0;
        n_compared = 0;
        nrst = 1'b0;
        lock = 1'b1;
        leg_pin = 1'b0;
        low_pin = 1'b0;
        traffic = 1'b1;
        pulse = 3'h0;
        rv = 8'($urandom(30));
        strap = 4'($urandom % 10);
        repeat (6) @(negedge clk_sys);
        nrst = 1'b1;
        repeat (8) @(negedge clk_sys);
        reset_mdl;
        for (i = 0; i < 6; i = i + 1) rcheck(i);
        check(bus_addr, eff(mdl[0]));
        $display("test reset values done");
        wreg(0, 8'($urandom) & 8'hFE);
        check(bus_addr, eff(mdl[0]));
        d = 8'($urandom) | 8'h01;
        wreg(0, d);
        repeat (3) @(negedge clk_sys);
        check(bus_addr, d[7:1]);
        rcheck(0);
        wreg(0, 8'($urandom) & 8'hFE);
        repeat (3) @(negedge clk_sys);
        check(bus_addr, eff(mdl[0]));
        $display("test bus address done");
        for (i = 0; i < 8; i = i + 1) begin
            leg_pin = 1'($urandom);
            low_pin = 1'($urandom);
            wreg(2, 8'($urandom) & 8'h7F);
            wreg(3, 8'($urandom));
            wreg(1, 8'($urandom) & 8'hFC);
            repeat (6) @(negedge clk_sys);
            rcheck(1);
            rcheck(2);
            rcheck(3);
            check(leg, mdl[2][3] ? mdl[2][2] : leg_pin);
            check(low, mdl[2][1] ? mdl[2][0] : low_pin);
            check({ret, crc, pdn, pas, ack}, {mdl[1][2], mdl[3][6:5], mdl[3][3:2]});
        end
        $display("test configuration done");
        wreg(2, 8'h40);
        repeat (3) @(negedge clk_sys);
        check(ode, 0);
        wreg(2, 8'hE0);
        repeat (3) @(negedge clk_sys);
        check(ode, 1);
        lock = 1'b0;
        repeat (9) @(negedge clk_sys);
        mdl[2] = mdl[2] & 8'h7F;
        rcheck(2);
        check({ode, osc}, 2'b01);
        wreg(2, 8'h50);
        repeat (3) @(negedge clk_sys);
        check(oss, 1);
        lock = 1'b1;
        repeat (9) @(negedge clk_sys);
        $display("test lock loss done");
        wreg(3, 8'h00);
        wreg(1, 8'h05);
        @(negedge clk_sys);
        check(lrst, 1);
        repeat (3) @(negedge clk_sys);
        check(lrst, 0);
        rcheck(3);
        rcheck(1);
        wreg(1, 8'h02);
        repeat (4) @(negedge clk_sys);
        for (i = 0; i < 4; i = i + 1) rcheck(i);
        check(bus_addr, eff(mdl[0]));
        $display("test soft resets done");
        // Filter on after the full reset: pulses of one, two and three clocks.
        traffic = 1'b0;
        repeat (10) @(negedge clk_sys);
        seen = 3'h0;
        pulse <= 3'h7;
        @(negedge clk_sys);
        pulse <= 3'h3;
        @(negedge clk_sys);
        pulse <= 3'h1;
        @(negedge clk_sys);
        pulse <= 3'h0;
        repeat (12) begin
            @(negedge clk_sys);
            seen = seen | {de_o, hs_o, vs_o};
        end
        check(seen, 3'h3);
        $display("test sync filter done");
        wrap_up;
    end
endmodule
